// ### dv/test_dual_temp_monitor_alarms.sv
/*
 Self-checking bench: host end and monitor end joined by the bus interface.
 Assumes shortened conversion, period and bit-time parameters.
*/
`timescale 1ns/100ps
module test_dual_temp_monitor_alarms;
	import tm_pkg::*;
	localparam logic [6:0] DEV = 7'h18;
	// Strap open/vcc: remote 85+5*5, local 70+5*5
	localparam logic [7:0] RCODE [9] = '{C_LHI_RD, C_LLO_RD, C_RHI_RD, C_RLO_RD, C_RSHUT,
		C_LSHUT, C_CFG_RD, 8'h30, C_DBAND};
	localparam logic [7:0] REXP [9] = '{8'h7f, 8'hc9, 8'h7f, 8'hc9, 8'h6e, 8'h5f, 8'h20,
		8'h00, 8'h06};
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic mode_sel = 1'b1;
	logic [7:0] t_loc = 8'h19;
	logic [7:0] t_rem = 8'h20;
	logic [2:0] t_frac = 3'h5;
	logic j_open = 1'b0;
	logic j_short = 1'b0;
	logic cmd_valid = 1'b0;
	tm_cmd_e cmd_kind = TM_READ_BYTE;
	logic [6:0] cmd_addr = DEV;
	logic [7:0] cmd_code = 8'h00;
	logic [7:0] cmd_data = 8'h00;
	logic cmd_ready, rsp_valid, rsp_nack, alert_seen, shut, busy;
	logic [7:0] rsp_data;
	logic [7:0] rd;
	logic nk;
	int n_fail = 0;
	int tests_run = 0;
	int cycles = 0;

	tm_smbus_if bus_if();
	tm_monitor #(.CONV_CYCLES(20), .PERIOD_CYCLES(60)) tm_monitor_i (.clock(clock), .rstn(rstn),
		.bus(bus_if), .alert_mode_select(mode_sel), .shutdown_strap_hi(STRAP_OPEN),
		.shutdown_strap_lo(STRAP_VCC), .meas_local(t_loc), .meas_remote(t_rem),
		.meas_frac(t_frac), .junction_open(j_open), .junction_short(j_short),
		.shutdown_alarm_out(shut), .conv_busy(busy));
	tm_host #(.QUARTER(8)) tm_host_i (.clock(clock), .rstn(rstn), .bus(bus_if),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr),
		.cmd_code(cmd_code), .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.rsp_nack(rsp_nack), .alert_seen(alert_seen));
	tm_properties #(.CONV_CYCLES(20)) tm_properties_i (.clock(clock), .rstn(rstn),
		.scl(bus_if.scl), .sda(bus_if.sda), .dev_sda_oe(bus_if.dev_sda_oe),
		.dev_alert_oe(bus_if.dev_alert_oe), .alert_mode_select(mode_sel), .conv_busy(busy));

	always #20 clock = ~clock;

	// Limit sized for some seventy frames of about 1300 cycles
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			n_fail++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic chk1(input string what, input logic seen, input logic exp);
		check(what, {7'h00, seen}, {7'h00, exp});
	endtask

	// Fields held from negedge until the taking edge; ready and response sampled at negedge
	task automatic op(input tm_cmd_e k, input logic [6:0] a, input logic [7:0] c,
		input logic [7:0] d);
		int n;
		@(negedge clock);
		cmd_kind = k;
		cmd_addr = a;
		cmd_code = c;
		cmd_data = d;
		cmd_valid = 1'b1;
		while (cmd_ready !== 1'b1) @(negedge clock);
		@(negedge clock);
		cmd_valid = 1'b0;
		for (n = 0; n < 4000 && rsp_valid !== 1'b1; n++) @(negedge clock);
		if (n == 4000) begin
			n_fail++;
		end
		rd = rsp_data;
		nk = rsp_nack;
	endtask

	task automatic rd_reg(input logic [7:0] c, input logic [7:0] e);
		op(TM_READ_BYTE, DEV, c, 8'h00);
		check($sformatf("reg %h", c), rd, e);
	endtask

	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		op(TM_WRITE_BYTE, DEV, c, d);
	endtask

	task automatic do_reset(input logic m);
		@(negedge clock);
		rstn = 1'b0;
		mode_sel = m;
		repeat (12) @(negedge clock);
		rstn = 1'b1;
		repeat (4) @(negedge clock);
	endtask

	initial begin
		do_reset(1'b1);
		op(TM_RECV_BYTE, DEV, 8'h00, 8'h00);
		check("recv after reset", rd, 8'h19);
		for (int i = 0; i < 9; i++) begin
			rd_reg(RCODE[i], REXP[i]);
		end
		op(TM_RECV_BYTE, DEV, 8'h00, 8'h00);
		check("recv pointer", rd, 8'h06);
		rd_reg(C_REMOTE, 8'h20);
		op(TM_READ_BYTE, DEV, C_FRAC, 8'h00);
		check("fraction", rd & 8'he0, 8'ha0);
		op(TM_READ_BYTE, 7'h19, C_LOCAL, 8'h00);
		chk1("foreign address", nk, 1'b1);
		$display("test reset done");
		t_loc = 8'he7;
		rd_reg(C_LOCAL, 8'h00);
		wr(C_CFG_WR, 8'h28);
		rd_reg(C_LOCAL, 8'he7);
		$display("test range done");
		t_loc = 8'h19;
		j_open = 1'b1;
		rd_reg(C_REMOTE, 8'h80);
		chk1("alert open", alert_seen, 1'b1);
		wr(C_CFG_WR, 8'h68);
		op(TM_READ_BYTE, DEV, C_STATUS, 8'h00);
		check("status open", rd & 8'h7f, 8'h04);
		chk1("alert read clear", alert_seen, 1'b0);
		op(TM_SEND_BYTE, DEV, C_ONESHOT, 8'h00);
		repeat (30) @(negedge clock);
		chk1("alert reassert", alert_seen, 1'b1);
		op(TM_ALERT_RESP, ARA_ADDR, 8'h00, 8'h00);
		check("responder address", rd, {DEV, 1'b0});
		chk1("alert resp clear", alert_seen, 1'b0);
		repeat (100) @(negedge clock);
		chk1("standby idle", busy, 1'b0);
		j_open = 1'b0;
		j_short = 1'b1;
		op(TM_SEND_BYTE, DEV, C_ONESHOT, 8'h00);
		rd_reg(C_REMOTE, 8'h80);
		op(TM_READ_BYTE, DEV, C_STATUS, 8'h00);
		check("status short", rd & 8'h7f, 8'h00);
		j_short = 1'b0;
		$display("test fault done");
		do_reset(1'b0);
		wr(C_LHI_WR, 8'h19);
		repeat (100) @(negedge clock);
		chk1("limit reached", alert_seen, 1'b1);
		op(TM_READ_BYTE, DEV, C_STATUS, 8'h00);
		check("status high", rd & 8'h7f, 8'h40);
		chk1("read keeps alert", alert_seen, 1'b1);
		wr(C_LHI_WR, 8'h1a);
		repeat (100) @(negedge clock);
		chk1("within limits", alert_seen, 1'b0);
		wr(C_DBAND, 8'h86);
		rd_reg(C_DBAND, 8'h06);
		t_loc = 8'h5f;
		repeat (100) @(negedge clock);
		chk1("shutdown on", shut, 1'b1);
		t_loc = 8'h5a;
		repeat (100) @(negedge clock);
		chk1("inside deadband", shut, 1'b1);
		t_loc = 8'h58;
		repeat (100) @(negedge clock);
		chk1("below deadband", shut, 1'b0);
		wr(C_LSHUT, 8'h50);
		rd_reg(C_LSHUT, 8'h50);
		chk1("new limit", shut, 1'b1);
		t_rem = 8'h6e;
		t_frac = 3'h3;
		repeat (100) @(negedge clock);
		rd_reg(C_REMOTE, 8'h6e);
		rd_reg(C_FRAC, 8'h60);
		op(TM_READ_BYTE, DEV, C_STATUS, 8'h00);
		check("status remote shutdown", rd & 8'h7f, 8'h43);
		$display("test comparator done");
		finish_test();
	end
endmodule // test_dual_temp_monitor_alarms

// ### dv/tm_properties.sv
/*
 Concurrent checks on the bus wires, alert line and conversion status.
 Assumes one clock domain, synchronous active-low reset, no bind.
*/
`timescale 1ns/100ps
module tm_properties #(
	parameter int CONV_CYCLES = 20
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic scl,
	input wire logic sda,
	input wire logic dev_sda_oe,
	input wire logic dev_alert_oe,
	input wire logic alert_mode_select,
	input wire logic conv_busy
);
	logic [7:0] busy_cnt_q;
	logic in_frame_q;

	always_ff @(posedge clock) begin
		if (!rstn) begin
			busy_cnt_q <= 8'h00;
		end else begin
			busy_cnt_q <= conv_busy ? busy_cnt_q + 8'h01 : 8'h00;
		end
	end

	// Start and stop seen on the wires, one cycle late
	always_ff @(posedge clock) begin
		if (!rstn) begin
			in_frame_q <= 1'b0;
		end else if (scl && $fell(sda)) begin
			in_frame_q <= 1'b1;
		end else if (scl && $rose(sda)) begin
			in_frame_q <= 1'b0;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	a_dev_data_edge: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("device data moved while clock high");
	a_scl_high_width: assert property ($rose(scl) |-> scl [*8])
		else $error("clock high phase too short");
	a_busy_bounded: assert property (conv_busy |-> busy_cnt_q <= CONV_CYCLES)
		else $error("conversion busy too long");
	a_busy_after_reset: assert property ($rose(rstn) |-> ##[1:2] conv_busy)
		else $error("no conversion after reset");
	a_alert_quiet_start: assert property ($rose(rstn) |-> !dev_alert_oe [*8])
		else $error("alert before first conversion");
	a_alert_rise_conv: assert property ($rose(dev_alert_oe) |->
		$past(conv_busy, 1) || $past(conv_busy, 2) || $past(conv_busy, 3))
		else $error("alert raised away from conversion end");
	a_int_clear_frame: assert property ($fell(dev_alert_oe) && alert_mode_select |-> in_frame_q)
		else $error("latched alert cleared outside a transfer");
	a_cmp_release_conv: assert property ($fell(dev_alert_oe) && !alert_mode_select |->
		$past(conv_busy, 1) || $past(conv_busy, 2) || $past(conv_busy, 3))
		else $error("comparator alert released away from conversion end");

	c_alert_rise: cover property ($rose(dev_alert_oe));
	c_alert_clear: cover property ($fell(dev_alert_oe) && in_frame_q);
	c_conv_end: cover property ($fell(conv_busy));
endmodule // tm_properties

// ### hdl/tm_host.sv
/*
 Master end: runs one byte protocol per command on the two-wire bus.
 Assumes no clock stretching by the slave; bit rate from a quarter-bit divider.
*/
`timescale 1ns/100ps
module tm_host #(
	parameter int QUARTER = tm_pkg::QUARTER_CYC
) (
	input wire logic clock,
	input wire logic rstn,
	tm_smbus_if.host bus,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire tm_pkg::tm_cmd_e cmd_kind,
	input wire logic [6:0] cmd_addr,
	input wire logic [7:0] cmd_code,
	input wire logic [7:0] cmd_data,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_nack,
	output logic alert_seen
);
	import tm_pkg::*;
	localparam int QW = $clog2(QUARTER + 1);
	if (QUARTER < 4) begin : g_chk
		$error("tm_host: quarter bit too short for the synchroniser");
	end

	typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} tm_mst_e;

	tm_mst_e st_q;
	logic [QW-1:0] qcnt_q;
	logic [1:0] ph_q, bi_q, last_q, last_d;
	logic [3:0] bit_q;
	logic [7:0] sh_q, rsh_q;
	logic rx_q, nack_q, scl_oe_q, sda_oe_q, rsp_q, sda_s, alert_s;
	// Entry: restart before, receive, byte
	logic [9:0] ent_q [4];
	logic [9:0] ent_d [4];

	tm_sync #(.W(2), .RST(2'h3)) u_sync (
		.clock(clock),
		.rstn(rstn),
		.d({bus.sda, bus.alert_n}),
		.q({sda_s, alert_s})
	);

	wire tick = qcnt_q == '0;
	wire [1:0] nxt = bi_q + 2'h1;
	wire [7:0] aw = {cmd_addr, 1'b0};
	wire [7:0] ar = {cmd_addr, 1'b1};
	// Deadband sign bit forced clear
	wire [7:0] wd = (cmd_code == C_DBAND) ? {1'b0, cmd_data[6:0]} : cmd_data;

	always_comb begin
		ent_d = '{default: 10'h000};
		last_d = 2'h1;
		unique case (cmd_kind)
			TM_WRITE_BYTE: begin
				ent_d[0] = {2'b00, aw};
				ent_d[1] = {2'b00, cmd_code};
				ent_d[2] = {2'b00, wd};
				last_d = 2'h2;
			end
			TM_READ_BYTE: begin
				ent_d[0] = {2'b00, aw};
				ent_d[1] = {2'b00, cmd_code};
				ent_d[2] = {2'b10, ar};
				ent_d[3] = {2'b01, ZERO8};
				last_d = 2'h3;
			end
			TM_SEND_BYTE: begin
				ent_d[0] = {2'b00, aw};
				ent_d[1] = {2'b00, cmd_code};
			end
			TM_RECV_BYTE: begin
				ent_d[0] = {2'b00, ar};
				ent_d[1] = {2'b01, ZERO8};
			end
			TM_ALERT_RESP: begin
				ent_d[0] = {2'b00, ARA_ADDR, 1'b1};
				ent_d[1] = {2'b01, ZERO8};
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rstn || tick)
			qcnt_q <= QW'(QUARTER - 1);
		else
			qcnt_q <= qcnt_q - 1'b1;
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			st_q <= H_IDLE;
			ph_q <= 2'h0;
			bit_q <= 4'h0;
			bi_q <= 2'h0;
			last_q <= 2'h0;
			sh_q <= ZERO8;
			rsh_q <= ZERO8;
			rx_q <= 1'b0;
			nack_q <= 1'b0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			rsp_q <= 1'b0;
			ent_q <= '{default: 10'h000};
		end else begin
			rsp_q <= 1'b0;
			if (st_q == H_IDLE) begin
				if (cmd_valid) begin
					ent_q <= ent_d;
					last_q <= last_d;
					bi_q <= 2'h0;
					nack_q <= 1'b0;
					ph_q <= 2'h0;
					st_q <= H_START;
				end
			end else if (tick) begin
				ph_q <= ph_q + 2'h1;
				unique case (st_q)
					H_START: unique case (ph_q)
						2'h0: sda_oe_q <= 1'b0;
						2'h1: scl_oe_q <= 1'b0;
						2'h2: sda_oe_q <= 1'b1;
						2'h3: begin
							scl_oe_q <= 1'b1;
							st_q <= H_BIT;
							bit_q <= 4'h0;
							sh_q <= ent_q[bi_q][7:0];
							rx_q <= ent_q[bi_q][8];
						end
					endcase
					H_BIT: unique case (ph_q)
						2'h0: sda_oe_q <= ~rx_q & ~bit_q[3] & ~sh_q[7];
						2'h1: scl_oe_q <= 1'b0;
						2'h2: if (!bit_q[3]) begin
							if (rx_q)
								rsh_q <= {rsh_q[6:0], sda_s};
							sh_q <= {sh_q[6:0], 1'b0};
						end else if (!rx_q && sda_s) begin
							nack_q <= 1'b1;
						end
						2'h3: begin
							scl_oe_q <= 1'b1;
							if (bit_q != BYTE_BITS) begin
								bit_q <= bit_q + 4'h1;
							end else if (nack_q || bi_q == last_q) begin
								st_q <= H_STOP;
							end else begin
								bi_q <= nxt;
								bit_q <= 4'h0;
								sh_q <= ent_q[nxt][7:0];
								rx_q <= ent_q[nxt][8];
								if (ent_q[nxt][9])
									st_q <= H_START;
							end
						end
					endcase
					H_STOP: unique case (ph_q)
						2'h0: sda_oe_q <= 1'b1;
						2'h1: scl_oe_q <= 1'b0;
						2'h2: sda_oe_q <= 1'b0;
						2'h3: begin
							st_q <= H_IDLE;
							rsp_q <= 1'b1;
						end
					endcase
					default: ;
				endcase
			end
		end
	end

	assign bus.host_scl_oe = scl_oe_q;
	assign bus.host_sda_oe = sda_oe_q;
	assign cmd_ready = st_q == H_IDLE;
	assign rsp_valid = rsp_q;
	assign rsp_data = rsh_q;
	assign rsp_nack = nack_q;
	assign alert_seen = ~alert_s;
endmodule // tm_host

// ### hdl/tm_monitor.sv
/*
 Device end: bus slave, registers, conversion control, alert and shutdown alarms.
 Assumes the analog front end presents readings on the system clock.
*/
`timescale 1ns/100ps
// Functional notes
// - One address; four byte protocols; pointer kept.
// - All locations are eight-bit registers.
// - Temperatures signed, one degree, MSB first.
// - Config bit 3 enables negatives to -64.
// - Fraction register holds three top bits.
// - Main and fraction updated together; host coordinates.
// - Host uses standby plus one-shot or busy.
// - Busy status bit set during conversion.
// - Junction fault loads remote with fault code.
// - Open junction sets status bit 2, alert.
// - No fault shown before first conversion.
// - High/low limits per channel drive alert.
// - High limits reset +127, low -55.
// - Mode pin high interrupt, low comparator.
// - Interrupt alerts latch; read or response clears.
// - Comparator alert follows out-of-limit condition.
// - Alert response sends address; lower wins.
// - Shutdown output compares with deadband hysteresis.
// - Reset loads shutdown limits from straps.
// - Deadband written positive, bit 7 zero.
// - Pointer resets to zero, local temperature.
// - One-shot starts now, ignored while busy.
// - Straps decode to nine threshold pairs.
// - Config bit 7 masks limits; bit 6 standby.
module tm_monitor #(
	parameter logic [6:0] DEV_ADDR = 7'h18,
	parameter int CONV_CYCLES = 2000,
	parameter int PERIOD_CYCLES = 12500
) (
	input wire logic clock,
	input wire logic rstn,
	tm_smbus_if.dev bus,
	input wire logic alert_mode_select,
	input wire logic [1:0] shutdown_strap_hi,
	input wire logic [1:0] shutdown_strap_lo,
	input wire logic [7:0] meas_local,
	input wire logic [7:0] meas_remote,
	input wire logic [2:0] meas_frac,
	input wire logic junction_open,
	input wire logic junction_short,
	output logic shutdown_alarm_out,
	output logic conv_busy
);
	import tm_pkg::*;
	localparam int CW = $clog2(PERIOD_CYCLES + 1);
	if (CONV_CYCLES < 1 || PERIOD_CYCLES <= CONV_CYCLES) begin : g_chk
		$error("tm_monitor: period must exceed conversion time");
	end

	typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_MACK, S_WAIT} tm_slv_e;

	function automatic logic [7:0] report(input logic [7:0] t, input logic ext);
		if (!t[7])
			return t;
		if (!ext)
			return ZERO8;
		return ($signed(t) < $signed(NEG_FLOOR)) ? NEG_FLOOR : t;
	endfunction

	// Nine-bit math so that limit minus deadband cannot wrap
	function automatic logic shut_next(input logic [7:0] t, lim, db, input logic cur);
		logic signed [8:0] lo_thr;
		lo_thr = $signed({lim[7], lim}) - $signed({2'b00, db[6:0]});
		if ($signed(t) >= $signed(lim))
			return 1'b1;
		if ($signed({t[7], t}) < lo_thr)
			return 1'b0;
		return cur;
	endfunction

	logic scl_s, sda_s, mode_s, scl_p, sda_p;
	logic [1:0] hi_s, lo_s, strap_wait_q;
	tm_slv_e st_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q, ptr_q, rd_data;
	logic [1:0] idx_q;
	logic rd_q, ara_q;
	logic [7:0] cfg_q, rate_q, lhi_q, llo_q, rhi_q, rlo_q, rshut_q, lshut_q, dband_q;
	logic [7:0] ltemp_q, rtemp_q, frac_q;
	logic [4:0] flags_q;
	logic lsd_q, rsd_q, alert_q, busy_q;
	logic [CW-1:0] ccnt_q, pcnt_q;

	tm_sync #(.W(7), .RST(7'h7f)) u_sync (
		.clock(clock),
		.rstn(rstn),
		.d({bus.scl, bus.sda, alert_mode_select, shutdown_strap_hi, shutdown_strap_lo}),
		.q({scl_s, sda_s, mode_s, hi_s, lo_s})
	);

	wire scl_rise = scl_s & ~scl_p;
	wire scl_fall = ~scl_s & scl_p;
	wire start_c = scl_s & scl_p & sda_p & ~sda_s;
	wire stop_c = scl_s & scl_p & ~sda_p & sda_s;
	wire byte_end = (st_q == S_RX) & scl_fall & (cnt_q == BYTE_BITS);
	wire addr_hit = sh_q[7:1] == DEV_ADDR;
	wire int_mode = mode_s;
	wire ara_hit = (sh_q[7:1] == ARA_ADDR) & sh_q[0] & int_mode & alert_q;
	wire ack_now = (idx_q == 2'h0) ? (addr_hit | ara_hit) : (~rd_q & (idx_q != 2'h3));
	wire cmd_stb = byte_end & (idx_q == 2'h1) & ~rd_q;
	wire wr_stb = byte_end & (idx_q == 2'h2) & ~rd_q;
	wire oneshot_stb = cmd_stb & (sh_q == C_ONESHOT);
	wire mack_done = (st_q == S_MACK) & scl_rise;
	wire stat_clr = mack_done & ~ara_q & (ptr_q == C_STATUS) & int_mode;
	wire ara_clr = mack_done & ara_q & int_mode;
	wire stop_wr = wr_stb & (ptr_q == C_CFG_WR) & sh_q[CFG_STOP];
	wire conv_done = busy_q & (ccnt_q == '0);
	// One-shot while busy is dropped, auto start only outside standby
	wire conv_start = ~busy_q & (oneshot_stb | (~cfg_q[CFG_STOP] & (pcnt_q == '0)));
	wire fault = junction_open | junction_short;
	wire [7:0] ltemp_n = report(meas_local, cfg_q[CFG_EXT]);
	wire [7:0] rtemp_n = fault ? FAULT_CODE : report(meas_remote, cfg_q[CFG_EXT]);
	wire [7:0] frac_n = fault ? ZERO8 : {meas_frac, 5'h00};
	wire lhi = $signed(ltemp_n) >= $signed(lhi_q);
	wire llo = $signed(ltemp_n) <= $signed(llo_q);
	wire rhi = ~fault & ($signed(rtemp_n) >= $signed(rhi_q));
	wire rlo = ~fault & ($signed(rtemp_n) <= $signed(rlo_q));
	wire [4:0] cond = {lhi, llo, rhi, rlo, junction_open};
	// Set wins over a clear landing in the same cycle
	wire [4:0] flags_d = int_mode ?
		((flags_q & ~{5{stat_clr | ara_clr}}) | (conv_done ? cond : 5'h00)) :
		(conv_done ? cond : flags_q);
	wire alert_act = (|flags_q[4:1] & ~cfg_q[CFG_MASK]) | flags_q[0];
	wire lsd_d = shut_next(ltemp_q, lshut_q, dband_q, lsd_q);
	wire rsd_d = shut_next(rtemp_q, rshut_q, dband_q, rsd_q);
	wire [7:0] status = {busy_q, flags_q, rsd_q, lsd_q};

	always_comb begin
		unique case (ptr_q)
			C_LOCAL: rd_data = ltemp_q;
			C_REMOTE: rd_data = rtemp_q;
			C_STATUS: rd_data = status;
			C_CFG_RD: rd_data = cfg_q;
			C_RATE_RD: rd_data = rate_q;
			C_LHI_RD: rd_data = lhi_q;
			C_LLO_RD: rd_data = llo_q;
			C_RHI_RD: rd_data = rhi_q;
			C_RLO_RD: rd_data = rlo_q;
			C_FRAC: rd_data = frac_q;
			C_RSHUT: rd_data = rshut_q;
			C_LSHUT: rd_data = lshut_q;
			C_DBAND: rd_data = dband_q;
			default: rd_data = ZERO8;
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			scl_p <= 1'b1;
			sda_p <= 1'b1;
		end else begin
			scl_p <= scl_s;
			sda_p <= sda_s;
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			st_q <= S_IDLE;
			cnt_q <= 4'h0;
			sh_q <= ZERO8;
			idx_q <= 2'h0;
			rd_q <= 1'b0;
			ara_q <= 1'b0;
			ptr_q <= PTR_RST;
		end else if (start_c) begin
			st_q <= S_RX;
			cnt_q <= 4'h0;
			idx_q <= 2'h0;
		end else if (stop_c) begin
			st_q <= S_IDLE;
		end else begin
			unique case (st_q)
				S_IDLE, S_WAIT: ;
				S_RX: if (scl_rise) begin
					sh_q <= {sh_q[6:0], sda_s};
					cnt_q <= cnt_q + 4'h1;
				end else if (byte_end) begin
					cnt_q <= 4'h0;
					st_q <= ack_now ? S_ACK : S_WAIT;
					if (idx_q != 2'h3)
						idx_q <= idx_q + 2'h1;
					if (idx_q == 2'h0) begin
						rd_q <= sh_q[0];
						ara_q <= ~addr_hit;
					end
					if (cmd_stb)
						ptr_q <= sh_q;
				end
				S_ACK: if (scl_fall) begin
					st_q <= rd_q ? S_TX : S_RX;
					sh_q <= ara_q ? {DEV_ADDR, 1'b0} : rd_data;
					cnt_q <= 4'h0;
				end
				S_TX: if (scl_rise) begin
					cnt_q <= cnt_q + 4'h1;
					if (sh_q[7] & ~sda_s)
						st_q <= S_WAIT;
				end else if (scl_fall) begin
					if (cnt_q == BYTE_BITS)
						st_q <= S_MACK;
					else
						sh_q <= {sh_q[6:0], 1'b0};
				end
				S_MACK: if (scl_rise)
					st_q <= S_WAIT;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			cfg_q <= CFG_RST;
			rate_q <= RATE_RST;
			lhi_q <= HI_RST;
			rhi_q <= HI_RST;
			llo_q <= LO_RST;
			rlo_q <= LO_RST;
			rshut_q <= HI_RST;
			lshut_q <= HI_RST;
			dband_q <= DBAND_RST;
			strap_wait_q <= 2'h3;
		end else begin
			if (strap_wait_q != 2'h0)
				strap_wait_q <= strap_wait_q - 2'h1;
			// Straps need the synchroniser filled before they are trusted
			if (strap_wait_q == 2'h1) begin
				rshut_q <= strap_thr(hi_s, lo_s, RSHUT_BASE);
				lshut_q <= strap_thr(hi_s, lo_s, LSHUT_BASE);
			end else if (wr_stb) begin
				unique case (ptr_q)
					C_CFG_WR: cfg_q <= {sh_q[7:1], 1'b0};
					C_RATE_WR: rate_q <= sh_q;
					C_LHI_WR: lhi_q <= sh_q;
					C_LLO_WR: llo_q <= sh_q;
					C_RHI_WR: rhi_q <= sh_q;
					C_RLO_WR: rlo_q <= sh_q;
					C_RSHUT: rshut_q <= sh_q;
					C_LSHUT: lshut_q <= sh_q;
					C_DBAND: dband_q <= sh_q;
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			busy_q <= 1'b0;
			ccnt_q <= '0;
			pcnt_q <= '0;
		end else if (stop_wr) begin
			busy_q <= 1'b0;
		end else if (conv_start) begin
			busy_q <= 1'b1;
			ccnt_q <= CW'(CONV_CYCLES - 1);
			pcnt_q <= CW'(PERIOD_CYCLES - 1);
		end else begin
			if (conv_done)
				busy_q <= 1'b0;
			else if (busy_q)
				ccnt_q <= ccnt_q - 1'b1;
			if (pcnt_q != '0)
				pcnt_q <= pcnt_q - 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			ltemp_q <= ZERO8;
			rtemp_q <= ZERO8;
			frac_q <= ZERO8;
			flags_q <= 5'h00;
			lsd_q <= 1'b0;
			rsd_q <= 1'b0;
			alert_q <= 1'b0;
			shutdown_alarm_out <= 1'b0;
		end else begin
			if (conv_done) begin
				ltemp_q <= ltemp_n;
				rtemp_q <= rtemp_n;
				frac_q <= frac_n;
			end
			flags_q <= flags_d;
			lsd_q <= lsd_d;
			rsd_q <= rsd_d;
			alert_q <= alert_act;
			shutdown_alarm_out <= lsd_d | rsd_d;
		end
	end

	assign bus.dev_sda_oe = (st_q == S_ACK) | ((st_q == S_TX) & ~sh_q[7]);
	assign bus.dev_alert_oe = alert_q;
	assign conv_busy = busy_q;
endmodule // tm_monitor

// ### hdl/tm_sync.sv
/*
 Two-stage synchroniser for pin inputs.
 Assumes inputs are levels slower than a few clock periods.
*/
`timescale 1ns/100ps
module tm_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;
	always_ff @(posedge clock) begin
		if (!rstn) begin
			meta_q <= RST;
			q <= RST;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule // tm_sync

// ### pkg/tm_pkg.sv
/*
 Shared constants for the two-channel temperature monitor and its bus master.
 Assumes a 25 MHz system clock on both ends.
*/
package tm_pkg;
	localparam logic [6:0] ARA_ADDR = 7'h0c;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [7:0] C_LOCAL = 8'h00;
	localparam logic [7:0] C_REMOTE = 8'h01;
	localparam logic [7:0] C_STATUS = 8'h02;
	localparam logic [7:0] C_CFG_RD = 8'h03;
	localparam logic [7:0] C_RATE_RD = 8'h04;
	localparam logic [7:0] C_LHI_RD = 8'h05;
	localparam logic [7:0] C_LLO_RD = 8'h06;
	localparam logic [7:0] C_RHI_RD = 8'h07;
	localparam logic [7:0] C_RLO_RD = 8'h08;
	localparam logic [7:0] C_CFG_WR = 8'h09;
	localparam logic [7:0] C_RATE_WR = 8'h0a;
	localparam logic [7:0] C_LHI_WR = 8'h0b;
	localparam logic [7:0] C_LLO_WR = 8'h0c;
	localparam logic [7:0] C_RHI_WR = 8'h0d;
	localparam logic [7:0] C_RLO_WR = 8'h0e;
	localparam logic [7:0] C_ONESHOT = 8'h0f;
	localparam logic [7:0] C_FRAC = 8'h10;
	localparam logic [7:0] C_RSHUT = 8'h19;
	localparam logic [7:0] C_LSHUT = 8'h20;
	localparam logic [7:0] C_DBAND = 8'h21;
	localparam logic [7:0] PTR_RST = 8'h00;
	localparam logic [7:0] CFG_RST = 8'h20;
	localparam logic [7:0] RATE_RST = 8'h02;
	localparam logic [7:0] HI_RST = 8'h7f;
	localparam logic [7:0] LO_RST = 8'hc9;
	localparam logic [7:0] DBAND_RST = 8'h06;
	localparam logic [7:0] FAULT_CODE = 8'h80;
	localparam logic [7:0] NEG_FLOOR = 8'hc0;
	localparam logic [7:0] ZERO8 = 8'h00;
	localparam int CFG_MASK = 7;
	localparam int CFG_STOP = 6;
	localparam int CFG_EXT = 3;
	localparam logic [1:0] STRAP_GND = 2'h0;
	localparam logic [1:0] STRAP_OPEN = 2'h1;
	localparam logic [1:0] STRAP_VCC = 2'h2;
	localparam logic [7:0] RSHUT_BASE = 8'h55;
	localparam logic [7:0] LSHUT_BASE = 8'h46;
	localparam logic [7:0] SHUT_STEP = 8'h05;
	localparam int CLK_NS = 40;
	localparam int BIT_TIME_NS = 10000;
	localparam int QUARTER_CYC = BIT_TIME_NS / (4 * CLK_NS);

	typedef enum logic [2:0] {
		TM_WRITE_BYTE, TM_READ_BYTE, TM_SEND_BYTE, TM_RECV_BYTE, TM_ALERT_RESP
	} tm_cmd_e;

	// Illegal strap code falls back to open, the pin's natural state
	function automatic logic [7:0] strap_thr(input logic [1:0] hi, lo, input logic [7:0] base);
		logic [7:0] h;
		logic [7:0] l;
		h = (hi == STRAP_VCC) ? 8'h02 : (hi == STRAP_GND) ? 8'h00 : 8'h01;
		l = (lo == STRAP_VCC) ? 8'h02 : (lo == STRAP_GND) ? 8'h00 : 8'h01;
		return 8'(base + 8'((h * 8'h03 + l) * SHUT_STEP));
	endfunction
endpackage

// ### pkg/tm_smbus_if.sv
/*
 Two-wire bus and alert line between the monitor and its master.
 Assumes pull-ups: a wire is low whenever any party enables its driver.
*/
`timescale 1ns/100ps
interface tm_smbus_if;
	logic host_scl_oe;
	logic host_sda_oe;
	logic dev_sda_oe;
	logic dev_alert_oe;
	logic scl;
	logic sda;
	logic alert_n;
	assign scl = ~host_scl_oe;
	assign sda = ~(host_sda_oe | dev_sda_oe);
	assign alert_n = ~dev_alert_oe;
	modport host (output host_scl_oe, output host_sda_oe, input sda, input alert_n);
	modport dev (output dev_sda_oe, output dev_alert_oe, input scl, input sda);
endinterface
